// ==== core/irqtb_top.sv ====
// Interrupt sources, vectoring and two time base generators behind an AHB-Lite slave.
// Assumes all inputs synchronous to hclk, one master, single word transfers.
//
// Behaviour
// RULE1: Selected pin edge sets external request flag.
// RULE2: Rising, falling, both, or disabled triggering.
// RULE3: Edge code 00 off,01 rise,10 fall,11 both.
// RULE4: External vectors only with global and own enable.
// RULE5: Pin needs enable, function select, input direction.
// RULE6: No call while stack full; request stays.
// RULE7: External service clears its flag and global.
// RULE8: Pull-high selection stays active as irq input.
// RULE9: Six serial conditions raise serial request.
// RULE10: Serial vectors only with global and own enable.
// RULE11: Serial service clears its flag and global.
// RULE12: Serial service leaves serial status flags alone.
// RULE13: Divider overflow sets time base flag periodically.
// RULE14: Time base vectors with global and own enable.
// RULE15: Time base service clears flag and global.
// RULE16: Source 00 sys, 01 sys/4, 1x sub.
// RULE17: Bit 7 runs generator, resets to zero.
// RULE18: Second period 2^4 up to 2^11.
// RULE19: Unimplemented bits read zero, ignore writes.
// RULE20: First period 2^0 up to 2^7.
// RULE21: Implemented control bits reset to zero.
`timescale 1ns/10ps
`include "irqtb_defs.svh"

module irqtb_top
    import irqtb_pkg::*;
#(
    parameter int TB_CNT_W = 11
) (
    input  wire logic           hclk,
    input  wire logic           hresetn,
    input  wire logic           hsel,
    input  wire logic [7:0]     haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic [31:0]    hwdata,
    input  wire logic           hready,
    output logic                hreadyout,
    output logic                hresp,
    output logic [31:0]         hrdata,
    input  wire logic           ext_irq_pin,
    input  wire logic           sub_clk,
    input  wire logic [5:0]     serial_events,
    input  wire logic           stack_full,
    input  wire logic           irq_return,
    output irqtb_call_type      irq_call,
    output logic                pin_pull_high
);

    irqtb_bus_type          bus_q;
    logic                   wr_pend_q;
    logic [7:0]             addr_q;
    logic [31:0]            hrdata_q;
    logic [1:0]             psc_q;
    logic                   tb0_run_q;
    logic [2:0]             tb0_per_q;
    logic                   tb1_run_q;
    logic [2:0]             tb1_per_q;
    logic [1:0]             edge_q;
    irqtb_vec_type          en_q;
    irqtb_vec_type          flag_q;
    irqtb_vec_type          flag_d;
    irqtb_vec_type          set_ev;
    irqtb_vec_type          svc_clr;
    logic                   gie_q;
    logic                   pin_fn_q;
    logic                   pin_in_q;
    logic                   pull_q;
    logic                   pin_prev_q;
    logic                   sub_prev_q;
    logic [1:0]             div4_q;
    logic                   psc_tick;
    logic [TB_CNT_W-1:0]    tb0_cnt_q;
    logic [TB_CNT_W-1:0]    tb1_cnt_q;
    logic                   pin_active;
    logic                   rise;
    logic                   fall;
    logic                   take;
    logic                   wr_irq;
    logic                   svc;
    irqtb_call_type         call_q;

    // Overflow when all low bits of the period are ones at a prescaled tick
    function automatic logic tb_wrap(input logic [TB_CNT_W-1:0] cnt, input logic [3:0] n);
        logic [TB_CNT_W-1:0] mask;
        mask = ~({TB_CNT_W{1'b1}} << n);
        tb_wrap = ((cnt & mask) == mask);
    endfunction

    // Word address match for a register, low two address bits ignored
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    // AHB-Lite response: writes no wait, reads one wait state
    assign take      = hsel && hready && htrans[1];
    assign hreadyout = (bus_q != BUS_RDWAIT);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign irq_call  = call_q;

    // Address phase capture and read wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_q     <= BUS_IDLE;
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else begin
            case (bus_q)
                BUS_IDLE: begin
                    if (take && !hwrite) begin
                        bus_q <= BUS_RDWAIT;
                    end
                end
                BUS_RDWAIT: begin
                    bus_q <= BUS_IDLE;
                end
                default: begin
                    bus_q <= BUS_IDLE;
                end
            endcase
            if (hready) begin
                wr_pend_q <= take && hwrite;
                if (take) begin
                    addr_q <= haddr;
                end
            end
        end
    end

    // Read data loaded in the wait state, unmapped reads as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (bus_q == BUS_RDWAIT) begin
            hrdata_q <= 32'h0000_0000; // see RULE19
            if (hit(addr_q, `IRQTB_OFF_PSC)) begin
                hrdata_q[1:0] <= psc_q;
            end
            if (hit(addr_q, `IRQTB_OFF_TB0)) begin
                hrdata_q[`IRQTB_TB_RUN_BIT] <= tb0_run_q;
                hrdata_q[2:0]               <= tb0_per_q;
            end
            if (hit(addr_q, `IRQTB_OFF_TB1)) begin
                hrdata_q[`IRQTB_TB_RUN_BIT] <= tb1_run_q;
                hrdata_q[2:0]               <= tb1_per_q;
            end
            if (hit(addr_q, `IRQTB_OFF_EDGE)) begin
                hrdata_q[1:0] <= edge_q;
            end
            if (hit(addr_q, `IRQTB_OFF_IRQ)) begin
                hrdata_q[0]     <= gie_q;
                hrdata_q[4:1]   <= en_q;
                hrdata_q[11:8]  <= flag_q;
            end
            if (hit(addr_q, `IRQTB_OFF_PIN)) begin
                hrdata_q[2:0] <= {pull_q, pin_in_q, pin_fn_q};
            end
        end
    end

    // Time base and prescaler control, only implemented bits stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            psc_q     <= `IRQTB_RST2; // see RULE21
            tb0_run_q <= 1'b0;        // see RULE17
            tb0_per_q <= `IRQTB_RST3;
            tb1_run_q <= 1'b0;
            tb1_per_q <= `IRQTB_RST3;
        end else if (wr_pend_q) begin
            if (hit(addr_q, `IRQTB_OFF_PSC)) begin
                psc_q <= hwdata[1:0]; // see RULE19
            end
            if (hit(addr_q, `IRQTB_OFF_TB0)) begin
                tb0_run_q <= hwdata[`IRQTB_TB_RUN_BIT];
                tb0_per_q <= hwdata[2:0];
            end
            if (hit(addr_q, `IRQTB_OFF_TB1)) begin
                tb1_run_q <= hwdata[`IRQTB_TB_RUN_BIT];
                tb1_per_q <= hwdata[2:0];
            end
        end
    end

    // Edge select and pin configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_q   <= `IRQTB_EDGE_OFF;
            pin_fn_q <= 1'b0;
            pin_in_q <= 1'b0;
            pull_q   <= 1'b0;
        end else if (wr_pend_q) begin
            if (hit(addr_q, `IRQTB_OFF_EDGE)) begin
                edge_q <= hwdata[1:0];
            end
            if (hit(addr_q, `IRQTB_OFF_PIN)) begin
                pin_fn_q <= hwdata[`IRQTB_PIN_FN_BIT];
                pin_in_q <= hwdata[`IRQTB_PIN_IN_BIT];
                pull_q   <= hwdata[`IRQTB_PIN_PU_BIT];
            end
        end
    end

    // Pull-high follows its selection whatever the pin function
    assign pin_pull_high = pull_q; // see RULE8

    // Prescaled clock: every cycle, every fourth, or each sub clock rise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div4_q     <= `IRQTB_RST2;
            sub_prev_q <= 1'b0;
        end else begin
            div4_q     <= div4_q + 2'h1;
            sub_prev_q <= sub_clk;
        end
    end

    always_comb begin
        case (psc_q) // see RULE16
            `IRQTB_PSC_SYS:  psc_tick = 1'b1;
            `IRQTB_PSC_DIV4: psc_tick = (div4_q == `IRQTB_DIV4_LAST);
            default:         psc_tick = sub_clk && !sub_prev_q;
        endcase
    end

    // Divider counters, held at zero while the generator is off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tb0_cnt_q <= '0;
            tb1_cnt_q <= '0;
        end else begin
            if (!tb0_run_q) begin
                tb0_cnt_q <= '0; // see RULE17
            end else if (psc_tick) begin
                tb0_cnt_q <= tb0_cnt_q + 1'b1;
            end
            if (!tb1_run_q) begin
                tb1_cnt_q <= '0;
            end else if (psc_tick) begin
                tb1_cnt_q <= tb1_cnt_q + 1'b1;
            end
        end
    end

    // Pin edge detector gated by the pin configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= ext_irq_pin;
        end
    end

    assign pin_active = en_q.ext && pin_fn_q && pin_in_q; // see RULE5
    assign rise       = ext_irq_pin && !pin_prev_q;
    assign fall       = !ext_irq_pin && pin_prev_q;

    // Hardware set events of the four request flags
    always_comb begin
        set_ev = '0;
        case (edge_q) // see RULE2
            `IRQTB_EDGE_RISE: set_ev.ext = pin_active && rise; // see RULE3
            `IRQTB_EDGE_FALL: set_ev.ext = pin_active && fall; // see RULE1
            `IRQTB_EDGE_BOTH: set_ev.ext = pin_active && (rise || fall);
            default:          set_ev.ext = 1'b0;
        endcase
        set_ev.ser = |serial_events; // see RULE9
        set_ev.tb0 = tb0_run_q && psc_tick &&
                     tb_wrap(tb0_cnt_q, `IRQTB_TB0_BASE + {1'b0, tb0_per_q}); // see RULE20
        set_ev.tb1 = tb1_run_q && psc_tick &&
                     tb_wrap(tb1_cnt_q, `IRQTB_TB1_BASE + {1'b0, tb1_per_q}); // see RULE18
    end

    // Service picks the highest pending enabled source
    assign svc = gie_q && !stack_full && ((flag_q & en_q) != '0); // see RULE6
    always_comb begin
        svc_clr = '0;
        if (svc) begin
            if (flag_q.ext && en_q.ext) begin
                svc_clr.ext = 1'b1; // see RULE4
            end else if (flag_q.ser && en_q.ser) begin
                svc_clr.ser = 1'b1; // see RULE10
            end else if (flag_q.tb0 && en_q.tb0) begin
                svc_clr.tb0 = 1'b1; // see RULE14
            end else begin
                svc_clr.tb1 = 1'b1;
            end
        end
    end

    assign wr_irq = wr_pend_q && hit(addr_q, `IRQTB_OFF_IRQ);

    // Flags: software write, service clear, then hardware set wins
    always_comb begin
        flag_d = flag_q;
        if (wr_irq) begin
            flag_d = hwdata[`IRQTB_IRQ_FLG_LSB +: 4];
        end
        flag_d = (flag_d & ~svc_clr) | set_ev; // see RULE7
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= `IRQTB_RST4;
            en_q   <= `IRQTB_RST4;
        end else begin
            flag_q <= flag_d; // see RULE13
            if (wr_irq) begin
                en_q <= hwdata[`IRQTB_IRQ_EN_LSB +: 4];
            end
        end
    end

    // Global enable: service clears, return sets, write loads bit 0
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gie_q <= 1'b0;
        end else if (wr_irq) begin
            gie_q <= hwdata[0];
        end else if (irq_return) begin
            gie_q <= 1'b1;
        end else if (svc) begin
            gie_q <= 1'b0; // see RULE11
        end
    end

    // Vector call pulse; serial status flags live outside and are untouched
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            call_q <= '{valid: 1'b0, src: SRC_EXT};
        end else begin
            call_q.valid <= svc; // see RULE12
            if (svc_clr.ext) begin
                call_q.src <= SRC_EXT;
            end else if (svc_clr.ser) begin
                call_q.src <= SRC_SER;
            end else if (svc_clr.tb0) begin
                call_q.src <= SRC_TB0; // see RULE15
            end else if (svc_clr.tb1) begin
                call_q.src <= SRC_TB1;
            end
        end
    end

    // Checks on the design's own internal signals and outputs
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence rise_seen_s;
        edge_q == `IRQTB_EDGE_RISE && pin_active && !pin_prev_q && ext_irq_pin;
    endsequence

    sequence read_taken_s;
        take && !hwrite && bus_q == BUS_IDLE;
    endsequence

    ext_rise_set_a: assert property (rise_seen_s |=> flag_q.ext) // see RULE1
        else $error("rising pin edge did not set external flag");
    ext_off_a: assert property (edge_q == `IRQTB_EDGE_OFF && !wr_irq |=> !$rose(flag_q.ext)) // see RULE3
        else $error("external flag set while edge detection off");
    ext_pin_gate_a: assert property (!pin_fn_q && !wr_irq |=> !$rose(flag_q.ext)) // see RULE5
        else $error("external flag set with pin function not selected");
    call_gate_a: assert property (call_q.valid |-> $past(gie_q) && !$past(stack_full)) // see RULE6
        else $error("vector call without global enable or with full stack");
    svc_clear_a: assert property (call_q.valid && call_q.src == SRC_EXT && !$past(set_ev.ext)
                                  && !$past(wr_irq) |-> !flag_q.ext) // see RULE7
        else $error("external flag not cleared by service");
    ser_set_a: assert property (serial_events != 6'h00 |=> flag_q.ser) // see RULE9
        else $error("serial event did not set serial flag");
    ser_gate_a: assert property (call_q.valid && call_q.src == SRC_SER |-> $past(en_q.ser)) // see RULE10
        else $error("serial vector taken without its enable");
    gie_drop_a: assert property (svc && !wr_irq && !irq_return |=> !gie_q ##1 !call_q.valid) // see RULE11
        else $error("global enable not cleared after service");
    div4_gap_a: assert property (psc_q == `IRQTB_PSC_DIV4 && psc_tick
                                 |=> (psc_q != `IRQTB_PSC_DIV4 || !psc_tick) [*3]) // see RULE16
        else $error("divide by four prescaler ticks too often");
    tb0_fast_a: assert property (tb0_run_q && tb0_per_q == 3'h0 && psc_q == `IRQTB_PSC_SYS
                                 && !wr_irq |=> flag_q.tb0) // see RULE20
        else $error("time base zero fastest period missed a tick");
    tb1_wrap_a: assert property (set_ev.tb1 |-> tb1_cnt_q[3:0] == 4'hF) // see RULE18
        else $error("time base one overflowed below sixteen counts");
    tb_off_a: assert property (!tb0_run_q |-> !set_ev.tb0 ##1 tb0_cnt_q == '0) // see RULE17
        else $error("stopped time base zero still counting");
    rd_wait_a: assert property (read_taken_s |=> !hreadyout ##1 hreadyout) // see RULE19
        else $error("read data phase not one wait state");

endmodule

// ==== include/irqtb_defs.svh ====
// Offsets, field positions, reset values and counts of the irq and time base block.
// Assumes inclusion by bare name from the core.
`ifndef IRQTB_DEFS_SVH
`define IRQTB_DEFS_SVH
`define IRQTB_OFF_PSC     8'h00
`define IRQTB_OFF_TB0     8'h04
`define IRQTB_OFF_TB1     8'h08
`define IRQTB_OFF_EDGE    8'h0C
`define IRQTB_OFF_IRQ     8'h10
`define IRQTB_OFF_PIN     8'h14
`define IRQTB_TB_RUN_BIT  7
`define IRQTB_IRQ_EN_LSB  1
`define IRQTB_IRQ_FLG_LSB 8
`define IRQTB_PIN_FN_BIT  0
`define IRQTB_PIN_IN_BIT  1
`define IRQTB_PIN_PU_BIT  2
`define IRQTB_RST2        2'h0
`define IRQTB_RST3        3'h0
`define IRQTB_RST4        4'h0
`define IRQTB_EDGE_OFF    2'h0
`define IRQTB_EDGE_RISE   2'h1
`define IRQTB_EDGE_FALL   2'h2
`define IRQTB_EDGE_BOTH   2'h3
`define IRQTB_PSC_SYS     2'h0
`define IRQTB_PSC_DIV4    2'h1
`define IRQTB_TB0_BASE    4'h0
`define IRQTB_TB1_BASE    4'h4
`define IRQTB_DIV4_LAST   2'h3
`endif

// ==== include/irqtb_pkg.sv ====
// Types shared by the irq and time base block.
// Assumes the defs header sits beside it.
package irqtb_pkg;
    typedef enum logic [1:0] {SRC_EXT, SRC_SER, SRC_TB0, SRC_TB1} irqtb_src_type;
    typedef struct packed {
        logic          valid;
        irqtb_src_type src;
    } irqtb_call_type;
    typedef struct packed {
        logic tb1;
        logic tb0;
        logic ser;
        logic ext;
    } irqtb_vec_type;
    typedef enum {BUS_IDLE, BUS_RDWAIT} irqtb_bus_type;
endpackage

// ==== tb/irq_sources_time_base_tb.sv ====
// Self-checking bench for the irq sources and time base block.
// Assumes the package, the core and the cpu model are compiled first.
`timescale 1ns/10ps

module irq_sources_time_base_tb
    import irqtb_pkg::*;
;
    logic           hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic           sub_clk, pin_req, full_req, auto_ret;
    logic           ext_irq_pin, stack_full, irq_return, pin_pull_high;
    logic [7:0]     haddr;
    logic [1:0]     htrans;
    logic [2:0]     hsize, sub_div;
    logic [5:0]     serial_events;
    logic [31:0]    hwdata, hrdata;
    irqtb_call_type irq_call;
    irqtb_src_type  last_src;
    int             call_cnt, gap, error_cnt, checked;

    irqtb_top irqtb_top_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_irq_pin, .sub_clk,
        .serial_events, .stack_full, .irq_return, .irq_call, .pin_pull_high
    );

    irqtb_cpu_model irqtb_cpu_model_inst (
        .hclk, .hresetn, .irq_call, .pin_req, .full_req, .auto_ret, .ext_irq_pin,
        .stack_full, .irq_return, .call_cnt, .last_src, .gap
    );

    // 200 MHz clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    // Slow sub clock level, one rise every eight cycles
    always @(posedge hclk) begin
        sub_div <= sub_div + 3'h1;
        sub_clk <= sub_div[2];
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // One AHB-Lite single word transfer; address and data phase wait on hready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, e);
    endtask

    // Wait for a call count under a bound
    task automatic wait_calls(input int n, input int lim);
        int t;
        t = 0;
        while (call_cnt < n && t < lim) begin
            @(posedge hclk);
            t++;
        end
        chk(call_cnt >= n, 32'h1);
    endtask

    // Reset values, writable bits and an unmapped address
    task automatic reg_case();
        logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
        logic [31:0] mask [4] = '{32'h3, 32'h87, 32'h87, 32'h3};
        for (int i = 0; i < 6; i++) rdc(offs[i], 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(offs[i], 32'hFFFFFFFF);
            rdc(offs[i], mask[i]);
            wr(offs[i], 32'h0);
        end
        wr(8'h20, 32'hFFFFFFFF);
        rdc(8'h20, 32'h0);
        chk(hresp, 32'h0);
    endtask

    // One pin edge under a given edge code, pin setup and enables
    task automatic ext_try(input logic [1:0] code, input logic rise, input logic [2:0] cfg,
                           input logic [4:0] ctl, input logic [31:0] ncall, input logic [31:0] rde);
        int c0;
        pin_req <= ~rise;
        wr(8'h0C, {30'h0, code});
        wr(8'h14, {29'h0, cfg});
        wr(8'h10, {27'h0, ctl});
        c0 = call_cnt;
        chk(pin_pull_high, cfg[2]);
        pin_req <= rise;
        cycles(6);
        chk(call_cnt - c0, ncall);
        rdc(8'h10, rde);
    endtask

    // Edge codes, pin gating, enables and a full stack
    task automatic ext_case();
        int c0;
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 2; r++) begin
                ext_try(c[1:0], r[0], 3'h7, 5'h03, c[1 - r], c[1 - r] ? 32'h2 : 32'h3);
            end
        end
        ext_try(2'h1, 1'b1, 3'h5, 5'h03, 32'h0, 32'h3);
        ext_try(2'h1, 1'b1, 3'h6, 5'h03, 32'h0, 32'h3);
        ext_try(2'h1, 1'b1, 3'h7, 5'h01, 32'h0, 32'h1);
        ext_try(2'h1, 1'b1, 3'h7, 5'h02, 32'h0, 32'h102);
        wr(8'h10, 32'h101);
        cycles(4);
        rdc(8'h10, 32'h101);
        full_req <= 1'b1;
        ext_try(2'h1, 1'b1, 3'h7, 5'h03, 32'h0, 32'h103);
        c0 = call_cnt;
        full_req <= 1'b0;
        cycles(6);
        chk(call_cnt - c0, 32'h1);
        rdc(8'h10, 32'h2);
    endtask

    // Each of the six serial conditions raises one call
    task automatic serial_case();
        int c0;
        for (int i = 0; i < 6; i++) begin
            wr(8'h10, 32'h5);
            c0 = call_cnt;
            serial_events <= 6'h01 << i;
            @(posedge hclk);
            serial_events <= 6'h00;
            cycles(6);
            chk(call_cnt - c0, 32'h1);
            chk({30'h0, last_src}, {30'h0, SRC_SER});
            rdc(8'h10, 32'h4);
        end
    endtask

    // Run one generator with returns enabled and measure the call spacing
    task automatic tb_case(input logic [1:0] src, input logic one, input logic [2:0] p, input int per);
        int c0;
        auto_ret <= 1'b1;
        wr(8'h00, {30'h0, src});
        wr(one ? 8'h08 : 8'h04, {24'h0, 5'h10, p});
        wr(8'h10, one ? 32'h11 : 32'h09);
        c0 = call_cnt;
        wait_calls(c0 + 3, 4 * per + 40);
        chk(gap, per);
        chk({30'h0, last_src}, {30'h0, one ? SRC_TB1 : SRC_TB0});
        auto_ret <= 1'b0;
        wr(one ? 8'h08 : 8'h04, 32'h0);
        wr(8'h10, 32'h0);
    endtask

    // Generators stopped: enables alone give no calls
    task automatic stop_case();
        int c0;
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h80);
        wr(8'h04, 32'h0);
        rdc(8'h10, 32'h400);
        wr(8'h10, 32'h19);
        c0 = call_cnt;
        cycles(300);
        chk(call_cnt - c0, 32'h0);
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #400000;
        error_cnt++;
        finish_test();
    end

    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        sub_div = 3'h0;
        sub_clk = 1'b0;
        pin_req = 1'b0;
        full_req = 1'b0;
        auto_ret = 1'b0;
        serial_events = 6'h00;
        error_cnt = 0;
        checked = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        reg_case();
        ext_case();
        serial_case();
        tb_case(2'h0, 1'b0, 3'h3, 8);
        tb_case(2'h0, 1'b0, 3'h7, 128);
        tb_case(2'h0, 1'b1, 3'h0, 16);
        tb_case(2'h0, 1'b1, 3'h7, 2048);
        tb_case(2'h1, 1'b1, 3'h1, 128);
        tb_case(2'h2, 1'b0, 3'h1, 16);
        tb_case(2'h3, 1'b0, 3'h0, 8);
        stop_case();
        finish_test();
    end
endmodule

// ==== tb/irqtb_cpu_model.sv ====
// Far side model: the request pin and the cpu that takes vectored calls.
// Assumes the bench steers pin level, stack state and return behaviour.
`timescale 1ns/10ps

module irqtb_cpu_model
    import irqtb_pkg::*;
(
    input  wire logic           hclk,
    input  wire logic           hresetn,
    input  wire irqtb_call_type irq_call,
    input  wire logic           pin_req,
    input  wire logic           full_req,
    input  wire logic           auto_ret,
    output logic                ext_irq_pin,
    output logic                stack_full,
    output logic                irq_return,
    output int                  call_cnt,
    output irqtb_src_type       last_src,
    output int                  gap
);
    int cyc_q;
    int last_q;

    // Pin is a plain input level; direction and function come from software
    assign ext_irq_pin = pin_req;
    // Full stack only when the bench asks for it
    assign stack_full  = full_req;

    // Counts calls, keeps source and spacing, returns one cycle later if asked
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc_q      <= 0;
            last_q     <= 0;
            call_cnt   <= 0;
            gap        <= 0;
            last_src   <= SRC_EXT;
            irq_return <= 1'b0;
        end else begin
            cyc_q      <= cyc_q + 1;
            irq_return <= irq_call.valid && auto_ret;
            if (irq_call.valid) begin
                call_cnt <= call_cnt + 1;
                last_src <= irq_call.src;
                gap      <= cyc_q - last_q;
                last_q   <= cyc_q;
            end
        end
    end
endmodule
